// ---- src/timer_pin_and_run_control.sv ----
// Timer pin function, port I/O and run/restart control with APB registers
//
// What this block does
// [R01] Function select 0 routes the pin to general-purpose port logic.
// [R02] Function select 1 makes the pin a timer pin.
// [R03] Port mode, direction 0: pin is an input, not driven.
// [R04] Port mode, direction 1: pin is driven as an output.
// [R05] Port mode drives the output value bit; it may clock the counter.
// [R06] Input value reads pin level or output value; writes ignored.
// [R07] Restart 1 while running zeroes counter on next tick, then clears.
// [R08] Writing restart 0 leaves counting untouched.
// [R09] Run bit 0 stops the counter and freezes a timer-driven pin.
// [R10] Hold also freezes the divide-by-two prescaler.
// [R11] All registers stay readable and writable during hold.
// [R12] Device reset beats hold and reinitialises the timer.
// [R13] Restart 0, run 0 holds everything; this is the reset state.
// [R14] Restart 0, run 1 continues from the previous state.
// [R15] Restart 1, run 0 holds all; restart stays set until released.
// [R16] Counter returns to zero when its increment reaches the period.
// [R17] Clock source 1 uses half core clock; 0 uses pin clock in timer mode, output value bit in port mode.
// [R18] Bus writes override simultaneous hardware register updates.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "timer_pin_defs.svh"

module timer_pin_and_run_control
    import timer_pin_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 32
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Timer pin
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    pin_timer_pin_function_select_t timer_pin_function_select_reg;
    clk_src_t clock_source_select_reg;
    logic pin_direction_reg;
    logic pin_output_value_reg;
    logic pin_input_value_reg;
    logic counter_restart_reg;
    logic counter_run_not_hold_reg;
    logic timer_out_reg;
    logic half_reg;
    logic [CNT_W-1:0] counter_reg;
    logic [CNT_W-1:0] counter_next;
    logic [CNT_W-1:0] period_reg;
    logic pin_sync1_reg;
    logic pin_sync2_reg;
    logic ext_prev_reg;
    logic ext_level;
    logic ext_rise;
    logic tick;
    logic wrap;
    logic apb_setup;
    logic apb_write;
    logic wr_ctrl;
    logic wr_period;
    logic wr_count;
    logic [31:0] ctrl_word;
    logic [31:0] read_word;
    logic read_hit;

    // ------------------------------------------------------------
    // Pin synchroniser and count sources
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        pin_sync1_reg <= timer_pin_i;
        pin_sync2_reg <= pin_sync1_reg;
    end

    // Port mode counts the output value bit instead of the pin
    assign ext_level = (timer_pin_function_select_reg == PIN_TIMER) ?
        pin_sync2_reg : pin_output_value_reg; // see [R05]

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            ext_prev_reg <= 1'b0;
        else if (counter_run_not_hold_reg)
            ext_prev_reg <= ext_level;
    end

    assign ext_rise = ext_level && !ext_prev_reg;

    // Prescaler only advances while running, so resume is exact
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            half_reg <= 1'b0;
        else if (counter_run_not_hold_reg)
            half_reg <= !half_reg; // see [R10]
    end

    assign tick = counter_run_not_hold_reg &&
        ((clock_source_select_reg == CLK_SRC_HALF) ? half_reg
                                                   : ext_rise); // see [R17]

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // No wait state: pready rises in the first access cycle
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;
    assign wr_ctrl = apb_write &&
        (paddr_i == ADDR_W'(`TMR_CTRL_OFS));
    assign wr_period = apb_write &&
        (paddr_i == ADDR_W'(`TMR_PERIOD_OFS));
    assign wr_count = apb_write &&
        (paddr_i == ADDR_W'(`TMR_COUNT_OFS));

    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`TMR_PIN_SEL_BIT] = timer_pin_function_select_reg;
        ctrl_word[`TMR_DIR_BIT] = pin_direction_reg;
        ctrl_word[`TMR_DOUT_BIT] = pin_output_value_reg;
        ctrl_word[`TMR_DIN_BIT] = pin_input_value_reg;
        ctrl_word[`TMR_RESTART_BIT] = counter_restart_reg;
        ctrl_word[`TMR_RUN_BIT] = counter_run_not_hold_reg;
        ctrl_word[`TMR_CLK_SEL_BIT] = clock_source_select_reg;
        ctrl_word[`TMR_STAT_BIT] = timer_out_reg;
    end

    // Reads are never blocked by hold
    always_comb
    begin
        read_word = 32'h0000_0000;
        read_hit = 1'b1;
        if (paddr_i == ADDR_W'(`TMR_CTRL_OFS))
            read_word = ctrl_word; // see [R11]
        else if (paddr_i == ADDR_W'(`TMR_PERIOD_OFS))
            read_word = 32'(period_reg);
        else if (paddr_i == ADDR_W'(`TMR_COUNT_OFS))
            read_word = 32'(counter_reg);
        else
            read_hit = 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= `TMR_WORD_RST;
        end
        else if (apb_setup && !pready_o)
        begin
            pready_o <= 1'b1;
            pslverr_o <= !read_hit;
            prdata_o <= pwrite_i ? `TMR_WORD_RST : read_word;
        end
        else
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            timer_pin_function_select_reg <= PIN_PORT;
            clock_source_select_reg <= CLK_SRC_PIN;
            pin_direction_reg <= `TMR_CTRL_RST;
            pin_output_value_reg <= `TMR_CTRL_RST;
            counter_run_not_hold_reg <= `TMR_CTRL_RST; // see [R12] [R13]
        end
        else if (wr_ctrl)
        begin
            timer_pin_function_select_reg <=
                pin_timer_pin_function_select_t'(pwdata_i[`TMR_PIN_SEL_BIT]);
            clock_source_select_reg <=
                clk_src_t'(pwdata_i[`TMR_CLK_SEL_BIT]);
            pin_direction_reg <= pwdata_i[`TMR_DIR_BIT];
            pin_output_value_reg <= pwdata_i[`TMR_DOUT_BIT];
            counter_run_not_hold_reg <= pwdata_i[`TMR_RUN_BIT]; // see [R14]
        end
    end

    // Writing 0 never cancels a pending restart; the write wins over
    // the hardware clear when both land together
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            counter_restart_reg <= `TMR_CTRL_RST;
        else if (wr_ctrl && pwdata_i[`TMR_RESTART_BIT])
            counter_restart_reg <= 1'b1; // see [R08] [R18]
        else if (counter_restart_reg && tick)
            counter_restart_reg <= 1'b0; // see [R07] [R15]
    end

    // Input value ignores writes; reset picks up the sampled pin
    always_ff @(posedge ref_clk_i)
    begin
        if (timer_pin_function_select_reg == PIN_PORT && pin_direction_reg &&
            !reset_i)
            pin_input_value_reg <= pin_output_value_reg; // see [R06]
        else
            pin_input_value_reg <= pin_sync2_reg; // see [R06]
    end

    // ------------------------------------------------------------
    // Counter and period
    // ------------------------------------------------------------
    assign counter_next = counter_reg + CNT_W'(1);
    assign wrap = (counter_next == period_reg);

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            period_reg <= CNT_W'(`TMR_WORD_RST);
        else if (wr_period)
            period_reg <= CNT_W'(pwdata_i);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            counter_reg <= CNT_W'(`TMR_WORD_RST); // see [R12]
        else if (wr_count)
            counter_reg <= CNT_W'(pwdata_i); // see [R18]
        else if (tick && counter_restart_reg)
            counter_reg <= CNT_W'(0); // see [R07]
        else if (tick)
            counter_reg <= wrap ? CNT_W'(0) : counter_next; // see [R16]
    end

    // Output only moves on a tick, so hold freezes the pin too
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            timer_out_reg <= 1'b0;
        else if (tick && !counter_restart_reg && wrap && !wr_count)
            timer_out_reg <= !timer_out_reg; // see [R09]
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            timer_pin_o <= 1'b0;
            timer_pin_oe_o <= 1'b0;
        end
        else if (timer_pin_function_select_reg == PIN_TIMER)
        begin
            timer_pin_o <= timer_out_reg; // see [R02]
            timer_pin_oe_o <= (clock_source_select_reg == CLK_SRC_HALF);
        end
        else
        begin
            timer_pin_o <= pin_output_value_reg; // see [R01] [R05]
            timer_pin_oe_o <= pin_direction_reg; // see [R03] [R04]
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_restart_fire;
        counter_restart_reg && tick && !wr_ctrl && !wr_count;
    endsequence
    sequence s_held_restart;
        counter_restart_reg && !counter_run_not_hold_reg && !wr_ctrl;
    endsequence
    a_restart_zeroes: assert property ( // see [R07]
        s_restart_fire |=> (counter_reg == '0) && !counter_restart_reg)
        else $error("restart did not zero the counter");
    a_restart_held: assert property ( // see [R15]
        s_held_restart |=> counter_restart_reg &&
            ($stable(counter_reg) || $past(wr_count)))
        else $error("restart acted while held");
    a_hold_count: assert property ( // see [R09]
        !counter_run_not_hold_reg && !wr_count |=> $stable(counter_reg))
        else $error("counter moved during hold");
    a_hold_prescale: assert property ( // see [R10]
        !counter_run_not_hold_reg |=> $stable(half_reg))
        else $error("prescaler moved during hold");
    a_port_input: assert property ( // see [R03]
        timer_pin_function_select_reg == PIN_PORT && !pin_direction_reg
            |=> !timer_pin_oe_o)
        else $error("input pin driven");
    a_port_output: assert property ( // see [R04]
        timer_pin_function_select_reg == PIN_PORT && pin_direction_reg
            |=> timer_pin_oe_o && timer_pin_o == $past(pin_output_value_reg))
        else $error("output pin not driven with output value");
    a_period_wrap: assert property ( // see [R16]
        tick && !counter_restart_reg && wrap && !wr_count
            |=> counter_reg == '0 && timer_out_reg != $past(timer_out_reg))
        else $error("counter missed the period wrap");
    a_write_wins: assert property ( // see [R18]
        wr_count |=> counter_reg == CNT_W'($past(pwdata_i)))
        else $error("bus write lost to counter update");
    a_apb_answer: assert property ( // see [R11]
        apb_setup && !pready_o |=> pready_o ##1 !pready_o)
        else $error("apb answer not one cycle");

endmodule

`default_nettype wire

// ---- src/timer_pin_defs.svh ----
// Register offsets, field positions and reset values of the timer block
`ifndef TIMER_PIN_DEFS_SVH
`define TIMER_PIN_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMR_CTRL_OFS 12'h000
`define TMR_PERIOD_OFS 12'h004
`define TMR_COUNT_OFS 12'h008

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMR_PIN_SEL_BIT 0
`define TMR_DIR_BIT 1
`define TMR_DOUT_BIT 2
`define TMR_DIN_BIT 3
`define TMR_RESTART_BIT 6
`define TMR_RUN_BIT 7
`define TMR_CLK_SEL_BIT 9
`define TMR_STAT_BIT 11

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define TMR_CTRL_RST 1'b0
`define TMR_WORD_RST 32'h0000_0000
`define TMR_CLK_NS 50
`define TMR_PRESCALE 2

`endif

// ---- src/timer_pin_pkg.sv ----
// Types shared by the timer pin and run control block
package timer_pin_pkg;
    typedef enum logic {
        PIN_PORT = 1'b0,
        PIN_TIMER = 1'b1
    } pin_timer_pin_function_select_t;
    typedef enum logic {
        CLK_SRC_PIN = 1'b0,
        CLK_SRC_HALF = 1'b1
    } clk_src_t;
endpackage

// ---- tb/timer_pin_model.sv ----
// Behavioural source on the far side of the timer pin
`timescale 1ns/1ns
`default_nettype none

module timer_pin_model
(
    // Clock
    input wire logic ref_clk_i,
    // Pin as driven by the block
    input wire logic timer_pin_o,
    input wire logic timer_pin_oe_o,
    // Resolved pin level
    output logic timer_pin_i
);
    logic ext_level = 1'b0;

    // Block wins the wire only while its enable is high
    assign timer_pin_i = timer_pin_oe_o ? timer_pin_o : ext_level;

    task automatic set_level(input logic v);
        @(posedge ref_clk_i);
        ext_level <= v;
    endtask

    // Slow pulses, well under half the core rate, survive the sync pipe
    task automatic pulses(input int n);
        for (int k = 0; k < n; k++)
        begin
            repeat (4) @(posedge ref_clk_i);
            ext_level <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            ext_level <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the timer pin and run control block
`timescale 1ns/1ns
`default_nettype none
`include "timer_pin_defs.svh"

module testbench;
    import timer_pin_pkg::*;
    localparam logic [11:0] CTL = `TMR_CTRL_OFS;
    localparam logic [11:0] PER = `TMR_PERIOD_OFS;
    localparam logic [11:0] CNT = `TMR_COUNT_OFS;
    localparam logic [31:0] B1 = 32'h0000_0001;
    localparam logic [31:0] FN = B1 << `TMR_PIN_SEL_BIT;
    localparam logic [31:0] DIR = B1 << `TMR_DIR_BIT;
    localparam logic [31:0] DO = B1 << `TMR_DOUT_BIT;
    localparam logic [31:0] DI = B1 << `TMR_DIN_BIT;
    localparam logic [31:0] GO = B1 << `TMR_RESTART_BIT;
    localparam logic [31:0] RUN = B1 << `TMR_RUN_BIT;
    localparam logic [31:0] CS = B1 << `TMR_CLK_SEL_BIT;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    typedef struct packed {logic on; logic err; logic [31:0] e, m;} note_t;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic [31:0] q;
    int failures = 0;
    int n_tests = 0;
    int k;
    int p;
    note_t notes[$];
    note_t nt;

    always #25 clk = ~clk;

    timer_pin_and_run_control i_timer_pin_and_run_control (
        .ref_clk_i(clk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .timer_pin_i(pin_in),
        .timer_pin_o(pin_out), .timer_pin_oe_o(pin_oe));

    timer_pin_model i_timer_pin_model (.ref_clk_i(clk),
        .timer_pin_o(pin_out), .timer_pin_oe_o(pin_oe),
        .timer_pin_i(pin_in));

    // -----------------------------------------------------------
    // Result watcher
    // -----------------------------------------------------------
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            nt = notes.pop_front();
            if (nt.on)
            begin
                n_tests++;
                if ({pslverr, prdata & nt.m} !== {nt.err, nt.e & nt.m})
                begin
                    failures++;
                    $display("BAD at %0t got %h exp %h", $time,
                        {pslverr, prdata & nt.m}, {nt.err, nt.e & nt.m});
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Bus and check tasks
    // -----------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic on = 1'b1,
        input logic err = 1'b0);
        notes.push_back({on, err, e, m});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic chk_pin(input logic oe, input logic v, input logic uv);
        // Pin outputs settle after the launching edge; look mid-cycle
        @(negedge clk);
        n_tests++;
        if (pin_oe !== oe || (uv && pin_out !== v))
        begin
            failures++;
            $display("BAD at %0t got %h exp %h", $time,
                {pin_oe, pin_out}, {oe, v});
        end
        @(posedge clk);
    endtask

    task automatic finish_test;
        $display("failures %0d checks %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    initial
    begin
        void'($urandom(87));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(CTL, 32'h0000_0000, ALL);
        rd(PER, 32'h0000_0000, ALL);
        rd(12'h00C, 32'h0000_0000, ALL, 1'b1, 1'b1);
        for (int v = 0; v < 2; v++)
        begin
            wr(CTL, DIR | (v[0] ? DO : 32'h0000_0000));
            chk_pin(1'b1, v[0], 1'b1);
            rd(CTL, DIR | (v[0] ? DO | DI : 32'h0000_0000), ALL);
        end
        wr(CTL, DO);
        chk_pin(1'b0, 1'b0, 1'b0);
        i_timer_pin_model.set_level(1'b1);
        repeat (4) @(posedge clk);
        rd(CTL, DI, DI);
        i_timer_pin_model.set_level(1'b0);
        wr(CTL, DI);
        repeat (4) @(posedge clk);
        rd(CTL, 32'h0000_0000, DI);
        // Output bit as count source; more edges than the period, so it wraps
        p = $urandom_range(3, 6);
        k = $urandom_range(7, 12);
        wr(PER, p);
        wr(CNT, 32'h0000_0000);
        for (int i = 0; i < k; i++)
        begin
            wr(CTL, RUN | DO);
            wr(CTL, RUN);
        end
        wr(CTL, 32'h0000_0000);
        rd(CNT, k % p, ALL);
        // External pin clock in timer mode
        k = $urandom_range(2, 6);
        wr(PER, ALL);
        wr(CNT, 32'h0000_0000);
        wr(CTL, FN | RUN);
        chk_pin(1'b0, 1'b0, 1'b0);
        i_timer_pin_model.pulses(k);
        repeat (6) @(posedge clk);
        wr(CTL, FN);
        rd(CNT, k, ALL);
        // Half core clock, hold, restart
        wr(CTL, FN | CS);
        chk_pin(1'b1, 1'b0, 1'b0);
        wr(CNT, 32'h0000_1000);
        wr(CTL, RUN | CS | FN);
        repeat (20) @(posedge clk);
        wr(CTL, CS | FN);
        rd(CNT, 32'h0000_1000, 32'hFFFF_FF00);
        rd(CNT, 32'h0000_0000, ALL, 1'b0);
        p = q;
        q = pin_out;
        repeat (10) @(posedge clk);
        chk_pin(1'b1, q[0], 1'b1);
        rd(CNT, p, ALL);
        wr(CNT, 32'h1234_5678);
        rd(CNT, 32'h1234_5678, ALL);
        wr(CTL, GO | CS);
        repeat (6) @(posedge clk);
        rd(CTL, GO, GO);
        rd(CNT, 32'h1234_5678, ALL);
        wr(CTL, RUN | CS);
        repeat (4) @(posedge clk);
        rd(CTL, 32'h0000_0000, GO);
        wr(CTL, CS);
        rd(CNT, 32'h0000_0000, 32'hFFFF_FF00);
        wr(CNT, 32'h0000_0055);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(CNT, 32'h0000_0000, ALL);
        rd(CTL, 32'h0000_0000, ALL);
        finish_test();
    end
endmodule

`default_nettype wire
